//--- verilog/dee_row_prog.sv
// Data EEPROM row programmer: array, row latches, control/status register and AXI4-Lite slave.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "dee_map.svh"

module dee_row_prog #(
  parameter int          ADDR_W      = 7,
  parameter int unsigned PROG_CYCLES = `DEE_PROG_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  ce_i,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire dee_pkg::dee_mem_req_s mem_req_i,
  output dee_pkg::dee_mem_rsp_s      mem_rsp_o,
  input  wire logic                  wait_for_interrupt_instr_i,
  input  wire logic                  active_halt_i,
  input  wire logic                  halt_i,
  input  wire logic                  readout_protect_i,
  input  wire logic                  protect_remove_i,
  output logic                       busy_o,
  output logic                       wait_o,
  output logic                       erase_done_o
);
  import dee_pkg::*;

  // The block is split into a few concerns, each kept in a clocked process of its own.
  // The register slave takes write address and write data in either order and answers once both are held.
  // The read side of the register slave answers one cycle after the address is taken.
  // The control bits live apart from the sequencer so that the hardware clear can be given priority
  // over a software write that lands in the same cycle.
  // The sequencer walks through idle, programming, full erase and halt.
  // The row latches collect the bytes of one row and are emptied at the end of a cycle.
  // The array itself has no reset, since the stored contents must outlive any reset of the logic.
  // The memory read port is registered, so the processor sees its byte one cycle after the request.
  // Power-mode status is registered as well and follows the sequencer by one cycle.
  //
  // Software sequence for one row:
  //   1. Write the control register with the latch bit set and the start bit clear.
  //   2. Write up to 32 bytes into the array range, all inside one row.
  //   3. Write the control register with both bits set to start the cycle.
  //   4. Poll the control register until both bits read zero again.
  // Only the row of the most recent latched write is programmed, so bytes written to other
  // rows between two starts land in the wrong row.

  localparam int          DEPTH   = 1 << ADDR_W;
  localparam int          ROW_W   = ADDR_W - `DEE_ROW_LSB;
  localparam logic [7:0]  CSR_RST = `DEE_CSR_RESET;

  dee_state_e                  state;
  logic [7:0]                  array_mem [DEPTH];
  logic [7:0]                  latch_data [`DEE_ROW_BYTES];
  logic [`DEE_ROW_BYTES-1:0]   latch_loaded;
  logic [ROW_W-1:0]            latch_row;
  logic                        latch_write_mode;
  logic                        program_start;
  logic [31:0]                 prog_cnt;
  logic [ADDR_W-1:0]           erase_ptr;
  logic                        aw_got;
  logic                        w_got;
  logic [11:0]                 aw_addr;
  logic [31:0]                 w_data;
  logic [3:0]                  w_strb;
  logic                        prog_end;
  logic                        csr_wr;
  logic                        lat_wr;
  logic                        pgm_wr;
  logic                        in_range;
  logic                        ext_blocked;
  logic                        arr_wr;
  logic                        wait_req;

  // Accesses above the array are outside the EEPROM range and are not answered.
  // An external access is one made by a debug or programming tool; read-out protection refuses
  // both its reads and its writes, while accesses made by the running program still pass.
  // A byte write into the array range only fills a latch; the array changes at the end of a cycle.
  assign in_range    = (mem_req_i.addr >> ADDR_W) == 16'h0000;
  assign ext_blocked = readout_protect_i && mem_req_i.ext;
  assign arr_wr      = ce_i && mem_req_i.req && mem_req_i.we && in_range && !ext_blocked
                       && latch_write_mode && !program_start && state == DEE_IDLE;
  assign prog_end    = state == DEE_PROG && prog_cnt == PROG_CYCLES - 1;
  assign wait_req    = wait_for_interrupt_instr_i || active_halt_i;

  // Register write decode; the byte holding the control bits must be enabled.
  // A write with that byte disabled is still answered with an okay response but changes nothing.
  assign csr_wr = aw_got && w_got && !s_axi_bvalid && aw_addr == `DEE_CSR_OFFSET && w_strb[0];
  assign lat_wr = w_data[`DEE_CSR_LAT_BIT];
  assign pgm_wr = w_data[`DEE_CSR_PGM_BIT];

  // Write address and write data are taken independently, the answer follows both.
  // Each channel is refused while its item is already held or while a response is pending,
  // which keeps at most one write in flight and avoids any buffering.
  // The read channel is refused while read data waits to be taken.
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DEE_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `DEE_CSR_OFFSET) ? `DEE_RESP_OKAY : `DEE_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data are registered; the status word gives the sequencer state so that software can
  // tell a running cycle from a wait, a halt or an erase in progress.
  // Unmapped addresses return zero with an error response.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DEE_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `DEE_RESP_OKAY;
        unique case (s_axi_araddr)
          `DEE_CSR_OFFSET:    s_axi_rdata <= {30'h0000_0000, latch_write_mode, program_start};
          `DEE_STATUS_OFFSET: s_axi_rdata <= {28'h000_0000, state == DEE_ERASE, state == DEE_HALT,
                                              wait_o, state == DEE_PROG};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DEE_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control bits; the hardware clear at cycle end wins over any software write.
  // A start request is honoured only when the latch bit is already set, the sequencer is idle
  // and no wait is requested, so a cycle never begins just as the block should go to sleep.
  // Clearing the start bit while a cycle runs ends the cycle without writing the array; the row
  // then keeps whatever it held, which software must treat as undefined.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      latch_write_mode <= CSR_RST[`DEE_CSR_LAT_BIT];
      program_start    <= CSR_RST[`DEE_CSR_PGM_BIT];
    end else if (ce_i) begin
      if (prog_end || state == DEE_HALT) begin
        latch_write_mode <= 1'b0;
        program_start    <= 1'b0;
      end else if (csr_wr) begin
        if (lat_wr) begin
          latch_write_mode <= 1'b1;
        end else if (!program_start) begin
          latch_write_mode <= 1'b0;
        end
        if (pgm_wr && latch_write_mode && state == DEE_IDLE && !wait_req) begin
          program_start <= 1'b1;
        end else if (!pgm_wr) begin
          program_start <= 1'b0;
        end
      end
    end
  end

  // Sequencer. Halt takes priority over every other event and abandons the running work.
  // A full erase is started only from idle and wipes one byte per cycle from the bottom up.
  // The programming counter runs a fixed number of cycles; its length sets the cycle time.
  // A reset in the middle of a cycle returns here to idle without touching the array again.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state     <= DEE_IDLE;
      prog_cnt  <= 32'h0000_0000;
      erase_ptr <= '0;
    end else if (ce_i) begin
      unique case (state)
        DEE_IDLE: begin
          prog_cnt <= 32'h0000_0000;
          if (halt_i) begin
            state <= DEE_HALT;
          end else if (protect_remove_i) begin
            erase_ptr <= '0;
            state     <= DEE_ERASE;
          end else if (program_start) begin
            state <= DEE_PROG;
          end
        end
        DEE_PROG: begin
          prog_cnt <= prog_cnt + 32'h0000_0001;
          if (halt_i) begin
            state <= DEE_HALT;
          end else if (prog_end || !program_start) begin
            state <= DEE_IDLE;
          end
        end
        DEE_ERASE: begin
          erase_ptr <= erase_ptr + ADDR_W'(1);
          if (halt_i) begin
            state <= DEE_HALT;
          end else if (erase_ptr == ADDR_W'(DEPTH - 1)) begin
            state <= DEE_IDLE;
          end
        end
        DEE_HALT: begin
          if (!halt_i) begin
            state <= DEE_IDLE;
          end
        end
      endcase
    end
  end

  // Latches rest at the erased value so a repeated write ANDs into the held byte.
  // A loaded flag per latch marks which bytes of the row are to be programmed; bytes never
  // written during this load leave their array location untouched.
  // The row address is taken from every latched write, so the last write names the row.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      latch_loaded <= '0;
      latch_row    <= '0;
      for (int i = 0; i < `DEE_ROW_BYTES; i++) begin
        latch_data[i] <= `DEE_ERASED_BYTE;
      end
    end else if (ce_i) begin
      if (prog_end || state == DEE_HALT || (csr_wr && !lat_wr && !program_start)) begin
        latch_loaded <= '0;
        for (int i = 0; i < `DEE_ROW_BYTES; i++) begin
          latch_data[i] <= `DEE_ERASED_BYTE;
        end
      end else if (arr_wr) begin
        latch_loaded[mem_req_i.addr[`DEE_ROW_LSB-1:0]] <= 1'b1;
        latch_data[mem_req_i.addr[`DEE_ROW_LSB-1:0]]   <=
          latch_data[mem_req_i.addr[`DEE_ROW_LSB-1:0]] & mem_req_i.wdata;
        latch_row <= mem_req_i.addr[ADDR_W-1:`DEE_ROW_LSB];
      end
    end
  end

  // Array contents carry no reset, so an aborted cycle leaves them as they were.
  // All loaded bytes of the row are written in the single cycle that ends programming.
  always_ff @(posedge clk_i) begin
    if (ce_i && !sys_rst_i) begin
      if (state == DEE_ERASE) begin
        array_mem[erase_ptr] <= `DEE_ERASED_BYTE;
      end else if (prog_end && !halt_i) begin
        for (int i = 0; i < `DEE_ROW_BYTES; i++) begin
          if (latch_loaded[i]) begin
            array_mem[{latch_row, 5'(i)}] <= latch_data[i];
          end
        end
      end
    end
  end

  // Read port: the latches have no path to it, only the array does.
  // A refused read leaves the enable low, which stands for an undriven data bus.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mem_rsp_o <= '0;
    end else if (ce_i) begin
      mem_rsp_o.oe    <= 1'b0;
      mem_rsp_o.rdata <= 8'h00;
      if (mem_req_i.req && !mem_req_i.we && in_range && !ext_blocked
          && !latch_write_mode && state != DEE_ERASE && state != DEE_HALT) begin
        mem_rsp_o.oe    <= 1'b1;
        mem_rsp_o.rdata <= array_mem[mem_req_i.addr[ADDR_W-1:0]];
      end
    end
  end

  // Status outputs. Wait is shown only when the sequencer is idle and no start is pending,
  // so a running cycle always completes before the block reports that it sleeps.
  // Busy covers both programming and erasing and lags the sequencer by one cycle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_o       <= 1'b0;
      busy_o       <= 1'b0;
      erase_done_o <= 1'b0;
    end else if (ce_i) begin
      wait_o       <= wait_req && state == DEE_IDLE && !program_start;
      busy_o       <= state == DEE_PROG || state == DEE_ERASE;
      erase_done_o <= state == DEE_ERASE && erase_ptr == ADDR_W'(DEPTH - 1);
    end
  end

endmodule

//--- verilog/dee_map.svh
// Register offsets, field positions, reset values and timing counts of the data EEPROM row programmer.
`ifndef DEE_MAP_SVH
`define DEE_MAP_SVH

`define DEE_CSR_OFFSET      12'h030
`define DEE_STATUS_OFFSET   12'h034
`define DEE_CSR_RESET       8'h00
`define DEE_CSR_PGM_BIT     0
`define DEE_CSR_LAT_BIT     1
`define DEE_ST_BUSY_BIT     0
`define DEE_ST_WAIT_BIT     1
`define DEE_ST_HALT_BIT     2
`define DEE_ST_ERASE_BIT    3
`define DEE_ROW_BYTES       32
`define DEE_ROW_LSB         5
`define DEE_ERASED_BYTE     8'hFF
`define DEE_CLK_PERIOD_PS   5000
`define DEE_PROG_TIME_NS    3000000
`define DEE_PROG_CYCLES     (`DEE_PROG_TIME_NS / (`DEE_CLK_PERIOD_PS / 1000))
`define DEE_RESP_OKAY       2'b00
`define DEE_RESP_SLVERR     2'b10

`endif

//--- verilog/dee_pkg.sv
// Types shared by the data EEPROM row programmer.
package dee_pkg;

  typedef enum logic [3:0] {
    DEE_IDLE  = 4'b0001,
    DEE_PROG  = 4'b0010,
    DEE_ERASE = 4'b0100,
    DEE_HALT  = 4'b1000
  } dee_state_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        ext;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dee_mem_req_s;

  typedef struct packed {
    logic       oe;
    logic [7:0] rdata;
  } dee_mem_rsp_s;

endpackage

//--- test/dee_row_prog_checker.sv
// Concurrent checks on the ports of the data EEPROM row programmer.
`timescale 1ns/1ps
module dee_row_prog_checker
  import dee_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 8
) (
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_bvalid,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire dee_pkg::dee_mem_req_s mem_req_i,
  input wire dee_pkg::dee_mem_rsp_s mem_rsp_o,
  input wire logic                  wait_for_interrupt_instr_i,
  input wire logic                  active_halt_i,
  input wire logic                  halt_i,
  input wire logic                  busy_o,
  input wire logic                  wait_o,
  input wire logic                  erase_done_o
);
  logic [15:0] run;
  logic        skip;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Runs cut short by halt or belonging to an erase are left out of the length check.
  always_ff @(posedge clk_i) begin
    run  <= (sys_rst_i || !busy_o) ? 16'h0 : run + 16'h1;
    skip <= sys_rst_i || (skip && busy_o) || halt_i || erase_done_o;
  end
  sequence s_read_req;
    mem_req_i.req && !mem_req_i.we;
  endsequence
  sequence s_halted;
    halt_i [*2];
  endsequence
  a_rsp_after_read: assert property (mem_rsp_o.oe |-> $past(mem_req_i.req) && !$past(mem_req_i.we))
    else $error("data driven without read");
  a_halt_no_data: assert property (s_halted ##0 s_read_req |=> !mem_rsp_o.oe)
    else $error("data driven in halt");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
    else $error("reserved bits not zero");
  a_wait_when_idle: assert property (wait_o && $past(wait_o) |-> !busy_o)
    else $error("wait while busy");
  a_wait_has_cause: assert property ($rose(wait_o) |-> $past(wait_for_interrupt_instr_i) || $past(active_halt_i))
    else $error("wait without request");
  a_prog_length: assert property ($fell(busy_o) && !skip && !erase_done_o |-> run == PROG_CYCLES)
    else $error("wrong programming length");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  a_erase_pulse: assert property (erase_done_o |=> !erase_done_o)
    else $error("erase done too long");
endmodule
bind dee_row_prog dee_row_prog_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (.clk_i, .sys_rst_i, .s_axi_awready,
  .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid, .mem_req_i, .mem_rsp_o, .wait_for_interrupt_instr_i,
  .active_halt_i, .halt_i, .busy_o, .wait_o, .erase_done_o);

//--- test/dee_cpu_model.sv
// Behavioural CPU core issuing byte accesses on the EEPROM memory port.
`timescale 1ns/1ps
module dee_cpu_model
  import dee_pkg::*;
(
  input  wire logic                  clk_i,
  output dee_pkg::dee_mem_req_s      req_o,
  input  wire dee_pkg::dee_mem_rsp_s rsp_i
);
  initial req_o = '0;
  // The model issues data accesses only and never fetches code from the array.
  // Released address and data are inverted so a stale value is never mistaken for a live one.
  task automatic access(input logic we, ext, input logic [15:0] a, input logic [7:0] wd,
                        output logic oe, output logic [7:0] rd);
    req_o <= '{1'b1, we, ext, a, wd};
    @(posedge clk_i);
    req_o <= '{1'b0, 1'b0, 1'b0, ~a, ~wd};
    @(negedge clk_i);
    oe = rsp_i.oe;
    rd = rsp_i.rdata;
    @(posedge clk_i);
  endtask
endmodule

//--- test/data_eeprom_row_programmer_bench.sv
// Self-checking bench for the data EEPROM row programmer.
`timescale 1ns/1ps
`include "dee_map.svh"
module data_eeprom_row_programmer_bench;
  import dee_pkg::*;
  logic         clk_i, sys_rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, busy_o, wait_o;
  logic         wait_for_interrupt_instr_i, active_halt_i, halt_i, readout_protect_i, protect_remove_i;
  logic         erase_done_o, oe;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, v;
  logic [1:0]   s_axi_bresp, s_axi_rresp, r;
  logic [7:0]   d;
  dee_mem_req_s mem_req_i;
  dee_mem_rsp_s mem_rsp_o;
  int           error_cnt, checked;
  dee_row_prog #(.PROG_CYCLES(40)) dut (.clk_i, .sys_rst_i, .ce_i(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mem_req_i, .mem_rsp_o, .wait_for_interrupt_instr_i, .active_halt_i, .halt_i,
    .readout_protect_i, .protect_remove_i, .busy_o, .wait_o, .erase_done_o);
  dee_cpu_model cpu (.clk_i, .req_o(mem_req_i), .rsp_i(mem_rsp_o));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [7:0] dv);
    logic ah, wh, bh;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, dv};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clk_i);
      ah = s_axi_awready;
      wh = s_axi_wready;
      bh = s_axi_bvalid;
      @(posedge clk_i);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end while (!bh);
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] dv);
    logic ah, rh;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk_i);
      ah = s_axi_arready;
      rh = s_axi_rvalid;
      dv = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_i);
      if (ah) s_axi_arvalid <= 1'b0;
    end while (!rh);
  endtask
  task automatic till_idle;
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((busy_o || erase_done_o) && n < 400);
    if (n >= 400) error_cnt++;
    @(posedge clk_i);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
  initial begin
    {sys_rst_i, s_axi_bready, s_axi_rready} = 3'b111;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {wait_for_interrupt_instr_i, active_halt_i, halt_i, readout_protect_i, protect_remove_i} = '0;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    axr(12'h030, v);
    chk(v, 32'h0, "csr reset");
    axr(12'h00C, v);
    chk(r, `DEE_RESP_SLVERR, "unmapped"); 
    axw(12'h030, 8'hFE);
    axr(12'h030, v);
    chk(v, 32'h2, "csr latch");
    cpu.access(1'b0, 1'b0, 16'h0021, 8'h00, oe, d);
    chk(oe, 1'b0, "read in latch mode");
    cpu.access(1'b1, 1'b0, 16'h0023, 8'hF0, oe, d);
    cpu.access(1'b1, 1'b0, 16'h0023, 8'h3C, oe, d);
    cpu.access(1'b1, 1'b0, 16'h0021, 8'h5A, oe, d);
    axw(12'h030, 8'h03);
    wait_for_interrupt_instr_i <= 1'b1;
    axr(12'h030, v);
    chk(v, 32'h3, "csr programming");
    axw(12'h030, 8'h01);
    axr(12'h030, v);
    chk(v, 32'h3, "latch clear refused");
    @(negedge clk_i);
    chk({busy_o, wait_o}, 2'b10, "wait deferred");
    till_idle();
    @(negedge clk_i);
    chk(wait_o, 1'b1, "wait after cycle");
    @(posedge clk_i);
    wait_for_interrupt_instr_i <= 1'b0;
    axr(12'h030, v);
    chk(v, 32'h0, "csr after cycle");
    cpu.access(1'b0, 1'b0, 16'h0023, 8'h00, oe, d);
    chk({oe, d}, 9'h130, "anded byte");
    cpu.access(1'b1, 1'b0, 16'h0023, 8'h00, oe, d);
    cpu.access(1'b0, 1'b0, 16'h0023, 8'h00, oe, d);
    chk({oe, d}, 9'h130, "write in read mode");
    axw(12'h030, 8'h02);
    cpu.access(1'b1, 1'b0, 16'h0040, 8'h11, oe, d);
    axw(12'h030, 8'h03);
    halt_i <= 1'b1;
    @(posedge clk_i);
    cpu.access(1'b0, 1'b0, 16'h0040, 8'h00, oe, d);
    chk(oe, 1'b0, "read in halt");
    halt_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    axr(12'h030, v);
    chk(v, 32'h0, "csr after halt");
    readout_protect_i <= 1'b1;
    cpu.access(1'b0, 1'b1, 16'h0021, 8'h00, oe, d);
    chk(oe, 1'b0, "external read");
    cpu.access(1'b0, 1'b0, 16'h0021, 8'h00, oe, d);
    chk({oe, d}, 9'h15A, "internal read");
    protect_remove_i <= 1'b1;
    @(posedge clk_i);
    protect_remove_i <= 1'b0;
    @(posedge clk_i);
    till_idle();
    cpu.access(1'b0, 1'b0, 16'h0021, 8'h00, oe, d);
    chk({oe, d}, {1'b1, `DEE_ERASED_BYTE}, "erased byte");
    axw(12'h030, 8'h02);
    axw(12'h030, 8'h03);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    axr(12'h030, v);
    chk(v, 32'h0, "csr after reset");
    summarize();
  end
endmodule
